/* vsbp_cfg.svh */
// constants for the secondary backplane port: widths, encodings, timing counts
// assumes a single 100 MHz clock shared by both ends
`ifndef VSBP_CFG_SVH
`define VSBP_CFG_SVH
`define VSBP_AD_W 32
`define VSBP_SPACE_SYS 2'h0
`define VSBP_SPACE_IO 2'h1
`define VSBP_SPACE_ALT 2'h2
`define VSBP_SPACE_IACK 2'h3
`define VSBP_PORT_32 2'h0
`define VSBP_PORT_16 2'h1
`define VSBP_PORT_8 2'h2
`define VSBP_PORT_NONE 2'h3
`define VSBP_SLV_AC_HOLD 4'h2
`define VSBP_SLV_DATA_WAIT 4'h2
`define VSBP_CNT_ZERO 4'h0
`define VSBP_CNT_ONE 4'h1
`endif

/* vsbp_pkg.sv */
// types shared by both ends of the backplane port
// assumes vsbp_cfg.svh is included first
`default_nettype none
package vsbp_pkg;
    typedef enum logic [2:0] {
        VSBP_M_IDLE = 3'h0,
        VSBP_M_ARB = 3'h1,
        VSBP_M_ADDR = 3'h3,
        VSBP_M_DATA = 3'h2,
        VSBP_M_END = 3'h6
    } vsbp_mstate_t;
    typedef enum logic [1:0] {
        VSBP_S_IDLE = 2'h0,
        VSBP_S_ADDR = 2'h1,
        VSBP_S_DATA = 2'h3,
        VSBP_S_DONE = 2'h2
    } vsbp_sstate_t;
endpackage
`default_nettype wire

/* vsbp_if.sv */
// backplane wires between the master end and the slave end
// open-collector lines resolve as wired-AND of the pull-downs; only err and irq take pulls from both ends
`default_nettype none
interface vsbp_if;
    logic [31:0] ad_m_out;
    logic ad_m_oe;
    logic [31:0] ad_s_out;
    logic ad_s_oe;
    logic [31:0] ad;
    logic pas_n;
    logic ds_n;
    logic wr_n;
    logic [1:0] space;
    logic [1:0] size;
    logic lock_n;
    logic m_err_pull;
    logic s_err_pull;
    logic err_n;
    logic s_ack_pull;
    logic ack_n;
    logic s_ac_pull;
    logic ac;
    logic [1:0] s_asack_pull;
    logic [1:0] asack_n;
    logic s_wait_pull;
    logic wait_n;
    logic m_breq_pull;
    logic breq_n;
    logic m_busy_pull;
    logic busy_n;
    logic bgin_n;
    logic bgout_n;
    logic m_irq_pull;
    logic s_irq_pull;
    logic irq_n;
    // ad with master drive first, then slave, else all ones; wired-AND resolution of open-collector lines
    assign ad = ad_m_oe ? ad_m_out : (ad_s_oe ? ad_s_out : 32'hFFFFFFFF);
    assign err_n = ~(m_err_pull | s_err_pull);
    assign ack_n = ~s_ack_pull;
    assign ac = ~s_ac_pull;
    assign asack_n = ~s_asack_pull;
    assign wait_n = ~s_wait_pull;
    assign breq_n = ~m_breq_pull;
    assign busy_n = ~m_busy_pull;
    assign irq_n = ~(m_irq_pull | s_irq_pull);
    modport master (
        output ad_m_out, ad_m_oe, pas_n, ds_n, wr_n, space, size, lock_n,
        output m_err_pull, m_breq_pull, m_busy_pull, bgout_n, m_irq_pull,
        input ad, err_n, ack_n, ac, asack_n, wait_n, breq_n, busy_n, bgin_n, irq_n
    );
    modport slave (
        output ad_s_out, ad_s_oe, s_err_pull, s_ack_pull, s_ac_pull,
        output s_asack_pull, s_wait_pull, s_irq_pull,
        input ad, pas_n, ds_n, wr_n, space, size, lock_n, err_n, irq_n
    );
endinterface
`default_nettype wire

/* vsbp_master.sv */
// master end of the backplane port: arbitration, address and data phases
// assumes the wires resolve in vsbp_if and all inputs are synchronous to clk
//
// Overview of operation
// - AD carries address, then data
// - PAS low starts address phase, owns bus
// - DS falling edge starts data phase
// - WR low write, high read
// - SPACE selects space or special cycle
// - LOCK low keeps bus from others
// - ERR falling ends data phase in error
// - SIZE gives byte count of transfer
// - ACK low means slave finished data
// - AC rising means all slaves finished address
// - AC low at ACK forces next address phase
// - ASACK selects responder and reports port width
// - WAIT low stretches either phase
// - ASACK with WAIT high, else AC rise
// - end data only on ACK/ERR with WAIT high
// - grant daisy chain BGIN to BGOUT
// - requester pulls BREQ
// - owner holds BUSY low
// - IRQ pulled for service
// - cache line neither driven nor used
`include "vsbp_cfg.svh"
`default_nettype none
module vsbp_master (
    input wire logic clk,
    input wire logic rst,
    vsbp_if.master bus,
    input wire logic req,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic req_write,
    input wire logic [1:0] req_space,
    input wire logic [1:0] req_size,
    input wire logic req_lock,
    input wire logic irq_req,
    output logic busy,
    output logic done,
    output logic err,
    output logic [31:0] rdata,
    output logic [1:0] port_width
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    vsbp_pkg::vsbp_mstate_t state;
    logic need_addr;
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic write_q;
    logic lock_q;
    logic asack_prev;
    logic ac_prev;
    logic grant;
    logic asack_fall;
    logic ac_rise;
    logic data_end;

    // grant arrives when bgin is low and busy is high, with no owner holding the bus
    assign grant = !bus.bgin_n && bus.busy_n;
    assign asack_fall = asack_prev && (bus.asack_n != 2'h3);
    assign ac_rise = !ac_prev && bus.ac;
    assign data_end = (!bus.ack_n || !bus.err_n) && bus.wait_n;

    // ----------------------------------------
    // edge history
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            asack_prev <= 1'h1;
            ac_prev <= 1'h1;
        end else begin
            asack_prev <= (bus.asack_n == 2'h3);
            ac_prev <= bus.ac;
        end
    end

    // ----------------------------------------
    // cycle sequencer
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= vsbp_pkg::VSBP_M_IDLE;
            need_addr <= 1'h1;
            addr_q <= 32'h0;
            wdata_q <= 32'h0;
            write_q <= 1'h0;
            lock_q <= 1'h0;
            bus.pas_n <= 1'h1;
            bus.ds_n <= 1'h1;
            bus.wr_n <= 1'h1;
            bus.space <= `VSBP_SPACE_SYS;
            bus.size <= 2'h0;
            bus.lock_n <= 1'h1;
            bus.ad_m_out <= 32'h0;
            bus.ad_m_oe <= 1'h0;
            bus.m_breq_pull <= 1'h0;
            bus.m_busy_pull <= 1'h0;
            busy <= 1'h0;
            done <= 1'h0;
            err <= 1'h0;
            rdata <= 32'h0;
            port_width <= `VSBP_PORT_NONE;
        end else begin
            done <= 1'h0;
            case (state)
                vsbp_pkg::VSBP_M_IDLE: begin
                    if (req) begin
                        addr_q <= req_addr;
                        wdata_q <= req_wdata;
                        write_q <= req_write;
                        lock_q <= req_lock;
                        bus.space <= req_space;
                        bus.size <= req_size;
                        busy <= 1'h1;
                        err <= 1'h0;
                        if (bus.m_busy_pull) begin
                            state <= vsbp_pkg::VSBP_M_ARB;
                        end else begin
                            bus.m_breq_pull <= 1'h1;
                            state <= vsbp_pkg::VSBP_M_ARB;
                        end
                    end
                end
                vsbp_pkg::VSBP_M_ARB: begin
                    if (bus.m_busy_pull || grant) begin
                        bus.m_breq_pull <= 1'h0;
                        bus.m_busy_pull <= 1'h1;
                        bus.wr_n <= !write_q;
                        bus.lock_n <= !lock_q;
                        bus.ad_m_out <= addr_q;
                        bus.ad_m_oe <= 1'h1;
                        if (need_addr && !bus.pas_n) begin
                            // a locked bus still low on pas needs a fresh falling edge
                            bus.pas_n <= 1'h1;
                        end else if (need_addr) begin
                            bus.pas_n <= 1'h0;
                            state <= vsbp_pkg::VSBP_M_ADDR;
                        end else begin
                            bus.ad_m_out <= wdata_q;
                            bus.ad_m_oe <= write_q;
                            bus.ds_n <= 1'h0;
                            state <= vsbp_pkg::VSBP_M_DATA;
                        end
                    end
                end
                vsbp_pkg::VSBP_M_ADDR: begin
                    if ((asack_fall && bus.wait_n) || (ac_rise && !bus.wait_n)) begin
                        port_width <= bus.asack_n;
                        bus.ad_m_out <= wdata_q;
                        bus.ad_m_oe <= write_q;
                        bus.ds_n <= 1'h0;
                        state <= vsbp_pkg::VSBP_M_DATA;
                    end
                end
                vsbp_pkg::VSBP_M_DATA: begin
                    if (data_end) begin
                        rdata <= bus.ad;
                        err <= !bus.err_n;
                        need_addr <= !bus.ac;
                        bus.ds_n <= 1'h1;
                        bus.ad_m_oe <= 1'h0;
                        state <= vsbp_pkg::VSBP_M_END;
                    end
                end
                vsbp_pkg::VSBP_M_END: begin
                    done <= 1'h1;
                    busy <= 1'h0;
                    if (!lock_q) begin
                        bus.pas_n <= 1'h1;
                        bus.lock_n <= 1'h1;
                        bus.m_busy_pull <= 1'h0;
                        need_addr <= 1'h1;
                    end
                    state <= vsbp_pkg::VSBP_M_IDLE;
                end
                default: begin
                    state <= vsbp_pkg::VSBP_M_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // grant chain, interrupt, unused pulls
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.bgout_n <= 1'h1;
            bus.m_irq_pull <= 1'h0;
            bus.m_err_pull <= 1'h0;
        end else begin
            // pass the grant on only when not requesting ourselves
            bus.bgout_n <= bus.bgin_n || bus.m_breq_pull;
            bus.m_irq_pull <= irq_req;
            bus.m_err_pull <= 1'h0;
        end
    end
endmodule
`default_nettype wire

/* vsbp_slave.sv */
// responding slave end of the backplane port with a one-word store
// assumes the wires resolve in vsbp_if; cache line is not connected
`include "vsbp_cfg.svh"
`default_nettype none
module vsbp_slave (
    input wire logic clk,
    input wire logic rst,
    vsbp_if.slave bus,
    input wire logic [31:0] match_addr,
    input wire logic [1:0] width,
    input wire logic force_err,
    input wire logic want_addr,
    input wire logic irq_req,
    output logic [31:0] stored,
    output logic selected,
    output logic hit
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    vsbp_pkg::vsbp_sstate_t state;
    logic [3:0] cnt;
    logic pas_prev;
    logic ds_prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pas_prev <= 1'h1;
            ds_prev <= 1'h1;
        end else begin
            pas_prev <= bus.pas_n;
            ds_prev <= bus.ds_n;
        end
    end

    // ----------------------------------------
    // responder
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= vsbp_pkg::VSBP_S_IDLE;
            cnt <= `VSBP_CNT_ZERO;
            stored <= 32'h0;
            selected <= 1'h0;
            hit <= 1'h0;
            bus.ad_s_out <= 32'h0;
            bus.ad_s_oe <= 1'h0;
            bus.s_ack_pull <= 1'h0;
            bus.s_err_pull <= 1'h0;
            bus.s_ac_pull <= 1'h0;
            bus.s_asack_pull <= 2'h0;
            bus.s_wait_pull <= 1'h0;
        end else begin
            hit <= 1'h0;
            case (state)
                vsbp_pkg::VSBP_S_IDLE: begin
                    if (pas_prev && !bus.pas_n) begin
                        bus.s_ac_pull <= 1'h1;
                        bus.s_wait_pull <= 1'h1;
                        cnt <= `VSBP_SLV_AC_HOLD;
                        selected <= (bus.ad == match_addr) &&
                            (bus.space != `VSBP_SPACE_IACK);
                        state <= vsbp_pkg::VSBP_S_ADDR;
                    end else if (selected && ds_prev && !bus.ds_n) begin
                        bus.s_wait_pull <= 1'h1;
                        cnt <= `VSBP_SLV_DATA_WAIT;
                        state <= vsbp_pkg::VSBP_S_DATA;
                    end else if (bus.pas_n) begin
                        selected <= 1'h0;
                    end
                end
                vsbp_pkg::VSBP_S_ADDR: begin
                    if (cnt != `VSBP_CNT_ZERO) begin
                        cnt <= cnt - `VSBP_CNT_ONE;
                    end else begin
                        bus.s_wait_pull <= 1'h0;
                        bus.s_ac_pull <= 1'h0;
                        if (selected) begin
                            bus.s_asack_pull <= ~width;
                        end
                        state <= vsbp_pkg::VSBP_S_IDLE;
                    end
                end
                vsbp_pkg::VSBP_S_DATA: begin
                    if (cnt != `VSBP_CNT_ZERO) begin
                        cnt <= cnt - `VSBP_CNT_ONE;
                        if (bus.wr_n) begin
                            bus.ad_s_out <= stored;
                            bus.ad_s_oe <= 1'h1;
                        end
                    end else begin
                        if (!bus.wr_n && !force_err) begin
                            stored <= bus.ad;
                        end
                        hit <= 1'h1;
                        bus.s_ac_pull <= want_addr;
                        bus.s_err_pull <= force_err;
                        bus.s_ack_pull <= !force_err;
                        bus.s_wait_pull <= 1'h0;
                        state <= vsbp_pkg::VSBP_S_DONE;
                    end
                end
                vsbp_pkg::VSBP_S_DONE: begin
                    if (bus.ds_n) begin
                        bus.s_ack_pull <= 1'h0;
                        bus.s_err_pull <= 1'h0;
                        bus.s_ac_pull <= 1'h0;
                        bus.ad_s_oe <= 1'h0;
                        // keep asack only for a locked follow-on without address phase
                        if (bus.pas_n || bus.lock_n || bus.s_ac_pull) begin
                            bus.s_asack_pull <= 2'h0;
                        end
                        state <= vsbp_pkg::VSBP_S_IDLE;
                    end
                end
                default: begin
                    state <= vsbp_pkg::VSBP_S_IDLE;
                end
            endcase
            // a locked bus keeps this slave for the current owner only
            if (bus.pas_n && bus.lock_n && state == vsbp_pkg::VSBP_S_IDLE) begin
                bus.s_asack_pull <= 2'h0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.s_irq_pull <= 1'h0;
        end else begin
            bus.s_irq_pull <= irq_req;
        end
    end
endmodule
`default_nettype wire

/* vsbp_monitor.sv */
// concurrent checks on the backplane wires between master and slave ends
// assumes one clock domain, active high asynchronous reset, wires from vsbp_if
`default_nettype none
module vsbp_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic ad_m_oe,
    input wire logic ad_s_oe,
    input wire logic pas_n,
    input wire logic ds_n,
    input wire logic wr_n,
    input wire logic [1:0] space,
    input wire logic [1:0] size,
    input wire logic lock_n,
    input wire logic ack_n,
    input wire logic err_n,
    input wire logic wait_n,
    input wire logic busy_n,
    input wire logic [1:0] asack_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // wire checks
    // ----------------------------------------
    owner_busy_a: assert property (!pas_n |-> !busy_n)
        else $error("pas low without busy");
    addr_drive_a: assert property ($fell(pas_n) |-> ad_m_oe)
        else $error("address phase without address");
    data_start_a: assert property ($fell(ds_n) |-> !pas_n && !busy_n)
        else $error("data phase outside ownership");
    data_end_a: assert property ($rose(ds_n) |-> $past(wait_n) && !($past(ack_n) && $past(err_n)))
        else $error("data phase ended early");
    kind_stable_a: assert property (!ds_n && !$fell(ds_n) |->
        $stable(wr_n) && $stable(space) && $stable(size))
        else $error("cycle kind changed in data phase");
    ack_in_data_a: assert property ($fell(ack_n) |-> !ds_n && !pas_n)
        else $error("ack outside data phase");
    read_drive_a: assert property ($rose(ad_s_oe) |-> wr_n && !ds_n)
        else $error("slave drove ad outside a read");
    no_contend_a: assert property (!(ad_m_oe && ad_s_oe))
        else $error("both ends drive ad");
    lock_owner_a: assert property (!lock_n |-> !busy_n)
        else $error("lock without ownership");
    asack_owner_a: assert property (asack_n != 2'h3 |-> !pas_n)
        else $error("asack outside address phase");
endmodule
`default_nettype wire

/* test_vsb_bus_port.sv */
// self-checking bench joining master and slave ends across the backplane wires
// assumes cfg header, package, interface, both ends and monitor compiled first
`default_nettype none
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: %s", $time, m); end end
module test_vsb_bus_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic [31:0] req_addr = 32'h0;
    logic [31:0] req_wdata = 32'h0;
    logic req_write = 1'b0;
    logic [1:0] req_space = 2'h0;
    logic [1:0] req_size = 2'h0;
    logic req_lock = 1'b0;
    logic m_irq = 1'b0;
    logic s_irq = 1'b0;
    logic bgin_n = 1'b0;
    logic [31:0] match_addr = 32'h00001230;
    logic [1:0] width = 2'h0;
    logic force_err = 1'b0;
    logic want_addr = 1'b0;
    logic busy;
    logic done;
    logic m_err;
    logic [31:0] rdata;
    logic [1:0] port_width;
    logic [31:0] stored;
    logic [1:0] asack_prev = 2'h3;
    logic s_sel;
    logic s_hit;
    int hit_cnt = 0;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    int asack_cnt = 0;
    vsbp_if vif();
    assign vif.bgin_n = bgin_n;
    vsbp_master u_vsbp_master (.clk(clk), .rst(rst), .bus(vif.master), .req(req),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_write(req_write),
        .req_space(req_space), .req_size(req_size), .req_lock(req_lock), .irq_req(m_irq),
        .busy(busy), .done(done), .err(m_err), .rdata(rdata), .port_width(port_width));
    vsbp_slave u_vsbp_slave (.clk(clk), .rst(rst), .bus(vif.slave), .match_addr(match_addr),
        .width(width), .force_err(force_err), .want_addr(want_addr), .irq_req(s_irq),
        .stored(stored), .selected(s_sel), .hit(s_hit));
    vsbp_monitor u_vsbp_monitor (.clk(clk), .rst(rst), .ad_m_oe(vif.ad_m_oe),
        .ad_s_oe(vif.ad_s_oe), .pas_n(vif.pas_n), .ds_n(vif.ds_n), .wr_n(vif.wr_n),
        .space(vif.space), .size(vif.size), .lock_n(vif.lock_n), .ack_n(vif.ack_n),
        .err_n(vif.err_n), .wait_n(vif.wait_n), .busy_n(vif.busy_n), .asack_n(vif.asack_n));
    always #5 clk = ~clk;
    // ----------------------------------------
    // watchers and closing
    // ----------------------------------------
    always @(negedge clk) begin
        if (vif.asack_n != 2'h3 && asack_prev == 2'h3) asack_cnt++;
        if (s_hit === 1'b1) hit_cnt++;
        asack_prev = vif.asack_n;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // one bus cycle from the master user side
    // ----------------------------------------
    task automatic run_cycle(input logic [31:0] a, input logic [31:0] d, input logic w,
            input logic [1:0] sp, input logic [1:0] sz);
        int n;
        logic pp;
        logic pd;
        n = 0;
        while (busy !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        pp = vif.pas_n;
        pd = vif.ds_n;
        {req_addr, req_wdata, req_write, req_space, req_size} = {a, d, w, sp, sz};
        req = 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (busy === 1'b1) req = 1'b0;
            if (vif.pas_n === 1'b0 && pp === 1'b1) `CHK(vif.ad, a, "address")
            if (vif.ds_n === 1'b0 && pd === 1'b1) begin
                `CHK({vif.wr_n, vif.space, vif.size}, {~w, sp, sz}, "kind")
                if (w) `CHK(vif.ad, d, "write data")
            end
            pp = vif.pas_n;
            pd = vif.ds_n;
        end while (done !== 1'b1 && n < 200);
        req = 1'b0;
        `CHK(done, 1'b1, "cycle never ended")
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_widths();
        for (int i = 0; i < 3; i++) begin
            width = i[1:0];
            run_cycle(match_addr, 32'hA5C30000 + i, 1'b1, 2'h0, 2'h0);
            `CHK(stored, 32'hA5C30000 + i, "stored word")
            `CHK(port_width, i[1:0], "port width")
            run_cycle(match_addr, 32'h0, 1'b0, 2'h0, 2'h0);
            `CHK(rdata, 32'hA5C30000 + i, "read word")
        end
        `CHK(hit_cnt, 6, "one slave hit per data phase")
        $display("test widths done");
    endtask
    task automatic t_kinds();
        for (int i = 0; i < 4; i++) begin
            run_cycle(match_addr, 32'h5A000000 + i, 1'b1, (i == 3) ? 2'h0 : i[1:0], i[1:0]);
            `CHK(m_err, 1'b0, "space and size cycle")
        end
        $display("test kinds done");
    endtask
    task automatic t_error();
        force_err = 1'b1;
        run_cycle(match_addr, 32'hDEAD0001, 1'b1, 2'h0, 2'h0);
        `CHK(m_err, 1'b1, "error ending")
        `CHK(stored, 32'h5A000003, "no capture on error")
        force_err = 1'b0;
        $display("test error done");
    endtask
    task automatic t_lock();
        int k;
        req_lock = 1'b1;
        want_addr = 1'b1;
        run_cycle(match_addr, 32'h11110000, 1'b1, 2'h0, 2'h2);
        repeat (2) @(negedge clk);
        `CHK({vif.pas_n, vif.busy_n}, 2'h0, "bus kept while locked")
        `CHK(s_sel, 1'b1, "slave kept while locked")
        k = asack_cnt;
        want_addr = 1'b0;
        run_cycle(match_addr, 32'h22220000, 1'b1, 2'h0, 2'h2);
        `CHK(asack_cnt, k + 1, "address phase repeated")
        k = asack_cnt;
        req_lock = 1'b0;
        run_cycle(match_addr, 32'h0, 1'b0, 2'h0, 2'h2);
        `CHK(asack_cnt, k, "address phase skipped")
        `CHK(rdata, 32'h22220000, "locked read")
        repeat (3) @(negedge clk);
        `CHK(vif.busy_n, 1'b1, "bus released")
        $display("test lock done");
    endtask
    task automatic t_arb();
        `CHK(vif.bgout_n, 1'b0, "idle grant forwarded")
        bgin_n = 1'b1;
        fork
            run_cycle(match_addr, 32'h0F0F0F0F, 1'b1, 2'h1, 2'h0);
            begin
                repeat (6) @(negedge clk);
                `CHK(vif.pas_n, 1'b1, "no start without grant")
                `CHK(vif.breq_n, 1'b0, "request pulled")
                `CHK(s_sel, 1'b0, "no responder before address")
                bgin_n = 1'b0;
            end
        join
        `CHK(stored, 32'h0F0F0F0F, "granted write")
        $display("test arbitration done");
    endtask
    task automatic t_irq();
        m_irq = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(vif.irq_n, 1'b0, "master interrupt")
        m_irq = 1'b0;
        s_irq = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(vif.irq_n, 1'b0, "slave interrupt")
        s_irq = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(vif.irq_n, 1'b1, "interrupt released")
        $display("test interrupt done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_widths();
        t_kinds();
        t_error();
        t_lock();
        t_arb();
        t_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
